// >>> rtl/gcd_pkg.sv
// Package of constants and types for the gated clock divider block
package gcd_pkg;

    localparam int NUM_BUF = 24;
    localparam int NUM_SYNC = 41;
    localparam int SEL_W = 6;
    localparam int SYNC_HI_W = NUM_SYNC - 32;
    localparam int XCVR_REL_STAGES = 2;
    localparam int RATIO_REL_STAGES = 0;

    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_RATIO = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_SEN_LO = 8'h0c;
    localparam logic [7:0] A_SEN_HI = 8'h10;
    localparam logic [7:0] A_SCLR_LO = 8'h14;
    localparam logic [7:0] A_SCLR_HI = 8'h18;
    localparam logic [7:0] A_XSTAT = 8'h1c;
    localparam logic [7:0] A_LEAF = 8'h20;
    localparam logic [7:0] A_BUF_BASE = 8'h40;

    // Control register fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_CLR = 1;
    localparam int CTRL_MODE = 2;
    localparam int CTRL_STAGE = 4;
    // Leaf register fields
    localparam int LEAF_CODE = 0;
    localparam int LEAF_CLR = 2;
    // Per-buffer configuration fields
    localparam int BCFG_CODE = 0;
    localparam int BCFG_EMASK = 3;
    localparam int BCFG_CMASK = 4;
    localparam int BCFG_SEL = 8;
    // Status fields
    localparam int STAT_RATIO = 0;
    localparam int STAT_PLAIN = 1;
    localparam int STAT_LEAF = 2;

    localparam logic [3:0] DIV_ONE = 4'h1;

    // Reset values
    localparam logic [4:0] CTRL_RST = 5'h01;
    localparam logic [2:0] CODE_RST = 3'h0;
    localparam logic [NUM_SYNC-1:0] SEN_RST = {NUM_SYNC{1'b1}};
    localparam logic [NUM_SYNC-1:0] SCLR_RST = '0;
    localparam logic [2:0] LEAF_RST = 3'h0;
    localparam logic [SEL_W+4:0] BCFG_RST = '0;

    typedef enum logic [1:0] {
        GCD_CE_SYNC,
        GCD_CE_ASYNC,
        GCD_CE_HARD3
    } gcd_ce_mode_t;

endpackage : gcd_pkg

// >>> rtl/gcd_div_core.sv
// Divider core: clear release sync, pausable counter, glitch-free output gate
`timescale 1ns/10ps
module gcd_div_core #(
    parameter int REL_STAGES = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clr,
    input wire logic run,
    input wire logic async_gate,
    input wire logic [3:0] ratio,
    // Outputs
    output logic clk_out,
    output logic active
);
    import gcd_pkg::*;

    typedef struct packed {
        logic [2:0] rel;
        logic [2:0] cnt;
        logic lvl;
    } gcd_core_t;

    gcd_core_t s_r;
    gcd_core_t s_nxt;
    logic rst_n;
    logic act;
    logic gate_r;
    logic [3:0] rel_full;
    logic [3:0] hi_len;

    assign rst_n = presetn & ~clr;
    assign rel_full = {s_r.rel, 1'b1};
    assign act = rel_full[REL_STAGES] & ~clr;
    assign hi_len = ratio >> 1;
    assign active = act & run;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rel = {s_r.rel[1:0], 1'b1};
        if (act && run) begin
            s_nxt.lvl = ({1'b0, s_r.cnt} < hi_len);
            if ({1'b0, s_r.cnt} == ratio - DIV_ONE) begin
                s_nxt.cnt = '0;
            end else begin
                s_nxt.cnt = 3'(s_r.cnt + 3'h1);
            end
        end
    end

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Gate takes the enable only while the clock is low, so no runt pulse; a clear closes it at once
    always_ff @(negedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_r <= 1'b0;
        end else begin
            gate_r <= act & run;
        end
    end

    // Ratio one passes the clock itself through the gate
    assign clk_out = (ratio == DIV_ONE) ? (pclk & (async_gate ? (act & run) : gate_r))
                                        : s_r.lvl;

endmodule : gcd_div_core

// >>> rtl/gcd_clock_divider.sv
// Clock divider block top: APB registers, gated buffers, leaf divider, transceiver group
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
module gcd_clock_divider (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock outputs
    output logic ratio_clk_out,
    output logic plain_clk_out,
    output logic leaf_clk_out,
    output logic [gcd_pkg::NUM_BUF-1:0] xcvr_clk_out
);
    import gcd_pkg::*;

    typedef struct packed {
        logic [4:0] ctrl;
        logic [2:0] code;
        logic [NUM_SYNC-1:0] sen;
        logic [NUM_SYNC-1:0] sclr;
        logic [2:0] leaf;
        logic [NUM_BUF-1:0][SEL_W+4:0] bcfg;
        logic [NUM_SYNC-1:0] sen_s1;
        logic [NUM_SYNC-1:0] sen_s2;
        logic [2:0] ce3;
        logic ce_stg;
        logic [31:0] rdata;
        logic err;
    } gcd_top_t;

    gcd_top_t s_r;
    gcd_top_t s_nxt;

    // Decoded views of the control, ratio and leaf registers, and core activity
    gcd_ce_mode_t ce_mode;
    logic ce_pre;
    logic ratio_run;
    logic ratio_async;
    logic [3:0] ratio_div;
    logic [3:0] leaf_div;
    logic ratio_act;
    logic plain_act;
    logic leaf_act;
    logic [NUM_BUF-1:0] xcvr_act;

    // APB decode
    logic setup_ph;
    logic wr_acc;
    logic buf_hit;
    logic [7:0] buf_off;
    logic [4:0] buf_idx;
    logic [31:0] rd_val;
    logic rd_ok;

    assign ce_mode = gcd_ce_mode_t'(s_r.ctrl[CTRL_MODE +: 2]);
    assign ratio_div = {1'b0, s_r.code} + DIV_ONE;
    assign leaf_div = DIV_ONE << s_r.leaf[LEAF_CODE +: 2];

    // Staging option adds one flop in front of the enable path
    assign ce_pre = s_r.ctrl[CTRL_STAGE] ? s_r.ce_stg : s_r.ctrl[CTRL_EN];

    always_comb begin
        ratio_run = ce_pre;
        ratio_async = 1'b0;
        unique case (ce_mode)
            GCD_CE_SYNC: begin
                ratio_run = ce_pre;
            end
            GCD_CE_ASYNC: begin
                ratio_run = ce_pre;
                ratio_async = 1'b1;
            end
            GCD_CE_HARD3: begin
                ratio_run = s_r.ce3[2];
            end
            default: begin
                ratio_run = ce_pre;
            end
        endcase
    end

    // APB phases
    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & s_r.err;
    assign prdata = s_r.rdata;

    assign buf_off = paddr - A_BUF_BASE;
    assign buf_idx = buf_off[6:2];
    // Offset bit 7 set would alias the upper half onto the buffer table
    assign buf_hit = (paddr >= A_BUF_BASE) && !buf_off[7] && ({3'h0, buf_idx} < 8'(NUM_BUF))
        && (paddr[1:0] == 2'h0);

    // Read data multiplexer
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        if (buf_hit) begin
            rd_val[SEL_W+4:0] = s_r.bcfg[buf_idx];
        end else begin
            unique case (paddr)
                A_CTRL: begin
                    rd_val[4:0] = s_r.ctrl;
                end
                A_RATIO: begin
                    rd_val[2:0] = s_r.code;
                end
                A_STATUS: begin
                    rd_val[STAT_RATIO] = ratio_act;
                    rd_val[STAT_PLAIN] = plain_act;
                    rd_val[STAT_LEAF] = leaf_act;
                end
                A_SEN_LO: begin
                    rd_val = s_r.sen[31:0];
                end
                A_SEN_HI: begin
                    rd_val[SYNC_HI_W-1:0] = s_r.sen[NUM_SYNC-1:32];
                end
                A_SCLR_LO: begin
                    rd_val = s_r.sclr[31:0];
                end
                A_SCLR_HI: begin
                    rd_val[SYNC_HI_W-1:0] = s_r.sclr[NUM_SYNC-1:32];
                end
                A_XSTAT: begin
                    rd_val[NUM_BUF-1:0] = xcvr_act;
                end
                A_LEAF: begin
                    rd_val[2:0] = s_r.leaf;
                end
                default: begin
                    rd_ok = 1'b0;
                end
            endcase
        end
    end

    // Next-state logic for registers and enable stages
    always_comb begin
        s_nxt = s_r;

        // Enable staging and three-stage enable path
        s_nxt.ce_stg = s_r.ctrl[CTRL_EN];
        s_nxt.ce3 = {s_r.ce3[1:0], ce_pre};

        // Shared enable synchronisers, two stages on the rising edge
        s_nxt.sen_s1 = s_r.sen;
        s_nxt.sen_s2 = s_r.sen_s1;

        // Read data and error are captured in the setup cycle
        if (setup_ph) begin
            s_nxt.rdata = pwrite ? '0 : rd_val;
            s_nxt.err = ~rd_ok;
        end

        // Writes land at the access edge
        if (wr_acc && !s_r.err) begin
            if (buf_hit) begin
                // Callers change code and masks only while the buffer is cleared
                s_nxt.bcfg[buf_idx] = pwdata[SEL_W+4:0];
            end else begin
                unique case (paddr)
                    A_CTRL: begin
                        s_nxt.ctrl = pwdata[4:0];
                    end
                    A_RATIO: begin
                        s_nxt.code = pwdata[2:0];
                    end
                    A_SEN_LO: begin
                        s_nxt.sen[31:0] = pwdata;
                    end
                    A_SEN_HI: begin
                        s_nxt.sen[NUM_SYNC-1:32] = pwdata[SYNC_HI_W-1:0];
                    end
                    A_SCLR_LO: begin
                        s_nxt.sclr[31:0] = pwdata;
                    end
                    A_SCLR_HI: begin
                        s_nxt.sclr[NUM_SYNC-1:32] = pwdata[SYNC_HI_W-1:0];
                    end
                    A_LEAF: begin
                        s_nxt.leaf = pwdata[2:0];
                    end
                    default: begin
                        s_nxt.err = s_r.err;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.code <= CODE_RST;
            s_r.sen <= SEN_RST;
            s_r.sclr <= SCLR_RST;
            s_r.leaf <= LEAF_RST;
            s_r.bcfg <= {NUM_BUF{BCFG_RST}};
            s_r.sen_s1 <= SEN_RST;
            s_r.sen_s2 <= SEN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Gated ratio buffer: release takes effect on the first edge
    gcd_div_core #(
        .REL_STAGES(RATIO_REL_STAGES)
    ) u_ratio (
        .pclk(pclk),
        .presetn(presetn),
        .clr(s_r.ctrl[CTRL_CLR]),
        .run(ratio_run),
        .async_gate(ratio_async),
        .ratio(ratio_div),
        .clk_out(ratio_clk_out),
        .active(ratio_act)
    );

    // Plain pass-through buffer: same core with enable held high
    gcd_div_core #(
        .REL_STAGES(RATIO_REL_STAGES)
    ) u_plain (
        .pclk(pclk),
        .presetn(presetn),
        .clr(1'b0),
        .run(1'b1),
        .async_gate(1'b0),
        .ratio(DIV_ONE),
        .clk_out(plain_clk_out),
        .active(plain_act)
    );

    // Leaf divider with power-of-two ratio and its own clear
    gcd_div_core #(
        .REL_STAGES(RATIO_REL_STAGES)
    ) u_leaf (
        .pclk(pclk),
        .presetn(presetn),
        .clr(s_r.leaf[LEAF_CLR]),
        .run(1'b1),
        .async_gate(1'b0),
        .ratio(leaf_div),
        .clk_out(leaf_clk_out),
        .active(leaf_act)
    );

    // Transceiver group, one core per buffer on a shared synchroniser
    generate
        for (genvar i = 0; i < NUM_BUF; i++) begin : g_xcvr
            logic [SEL_W-1:0] sel_raw;
            logic [SEL_W-1:0] sel;
            logic emask;
            logic cmask;
            logic run_eff;
            logic clr_eff;
            logic [3:0] div;

            assign sel_raw = s_r.bcfg[i][BCFG_SEL +: SEL_W];
            // Out-of-range routing falls back to synchroniser zero
            assign sel = (32'(sel_raw) < NUM_SYNC) ? sel_raw : '0;
            assign emask = s_r.bcfg[i][BCFG_EMASK];
            assign cmask = s_r.bcfg[i][BCFG_CMASK];
            assign run_eff = emask | s_r.sen_s2[sel];
            assign clr_eff = ~cmask & s_r.sclr[sel];
            assign div = {1'b0, s_r.bcfg[i][BCFG_CODE +: 3]} + DIV_ONE;

            // Same synchroniser and same edges keep the group in phase
            gcd_div_core #(
                .REL_STAGES(XCVR_REL_STAGES)
            ) u_core (
                .pclk(pclk),
                .presetn(presetn),
                .clr(clr_eff),
                .run(run_eff),
                .async_gate(1'b0),
                .ratio(div),
                .clk_out(xcvr_clk_out[i]),
                .active(xcvr_act[i])
            );
        end
    endgenerate

endmodule : gcd_clock_divider

// >>> verification/gcd_clock_divider_chk.sv
// Port checker for the clock divider block
`timescale 1ns/10ps
module gcd_clock_divider_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Clocks
    input wire logic ratio_clk_out,
    input wire logic plain_clk_out
);
    import gcd_pkg::*;
    logic [4:0] ctrl_r;
    logic [2:0] code_r;
    logic [4:0] age_r;
    logic [3:0] hc_r;
    logic [3:0] lc_r;
    logic wr_ok;
    logic steady;
    logic [3:0] n_w;
    assign wr_ok = psel && penable && pwrite && pready;
    assign n_w = {1'b0, code_r} + 4'h1;
    assign steady = ctrl_r == 5'h01 && code_r != 3'h0 && age_r > 5'h10;
    // Shadow of control and ratio, phase lengths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
            code_r <= CODE_RST;
            age_r <= 5'h0;
            hc_r <= 4'h0;
            lc_r <= 4'h0;
        end else begin
            if (wr_ok && paddr == A_CTRL)
                ctrl_r <= pwdata[4:0];
            if (wr_ok && paddr == A_RATIO)
                code_r <= pwdata[2:0];
            age_r <= (wr_ok && paddr inside {A_CTRL, A_RATIO}) ? 5'h0 : age_r + {4'h0, age_r != 5'h1f};
            hc_r <= ratio_clk_out ? hc_r + 4'h1 : 4'h0;
            lc_r <= ratio_clk_out ? 4'h0 : lc_r + 4'h1;
        end
    end
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_CLR_HOLD: assert property (ctrl_r[1] |-> !ratio_clk_out)
        else $error("ratio clock high while cleared");
    AST_CLR_NOW: assert property (@(negedge pclk) ctrl_r[1] |-> !ratio_clk_out)
        else $error("ratio clock high after clear");
    AST_RATIO_ONE: assert property (
        @(negedge pclk) ctrl_r == 5'h01 && code_r == 3'h0 && age_r > 5'h2 |-> ratio_clk_out)
        else $error("ratio one output not following clock");
    AST_PLAIN: assert property (@(negedge pclk) $past(presetn) |-> plain_clk_out)
        else $error("plain output not following clock");
    AST_FIRST_RISE: assert property (
        $fell(ctrl_r[1]) && ctrl_r == 5'h01 && code_r != 3'h0 |-> !ratio_clk_out ##1 ratio_clk_out)
        else $error("no rise on first edge after clear");
    AST_HIGH_LEN: assert property (steady && $fell(ratio_clk_out) |-> hc_r == n_w >> 1)
        else $error("high phase length wrong");
    AST_LOW_LEN: assert property (steady && $rose(ratio_clk_out) |-> lc_r == n_w - (n_w >> 1))
        else $error("low phase length wrong");
    AST_FREEZE: assert property (
        ctrl_r == 5'h00 ##1 (ctrl_r == 5'h00 && code_r != 3'h0) |=> ($stable(ratio_clk_out) || ctrl_r[1]))
        else $error("output moved while disabled");
    cover property (steady && $fell(ratio_clk_out));
    cover property ($fell(ctrl_r[1]) && code_r != 3'h0);
    cover property (ctrl_r == 5'h00 && ratio_clk_out);
endmodule : gcd_clock_divider_chk

// >>> verification/gcd_ctl_model.sv
// Fabric control model: bus master setting enable, clear, ratios and masks
`timescale 1ns/10ps
module gcd_ctl_model (
    // Clock
    input wire logic pclk,
    // Bus
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show no stale value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : gcd_ctl_model

// >>> verification/gcd_clock_divider_tb.sv
// Testbench for the clock divider block
`timescale 1ns/10ps
module gcd_clock_divider_tb;
    import gcd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic ratio_clk_out, plain_clk_out, leaf_clk_out;
    logic [NUM_BUF-1:0] xcvr_clk_out;
    int fail_count = 0;
    int compares = 0;
    int seed = 32'h91815076;
    int code, hi, lo, n;
    int ex[$];
    logic [7:0] ra[6] = '{A_CTRL, A_RATIO, A_LEAF, A_SEN_LO, A_SEN_HI, 8'h24};
    logic [31:0] rv[6] = '{32'(CTRL_RST), 32'(CODE_RST), 32'(LEAF_RST), SEN_RST[31:0],
        32'(SEN_RST[NUM_SYNC-1:32]), 32'h0};
    always #2.5 pclk = ~pclk;
    gcd_clock_divider dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ratio_clk_out(ratio_clk_out), .plain_clk_out(plain_clk_out), .leaf_clk_out(leaf_clk_out),
        .xcvr_clk_out(xcvr_clk_out));
    gcd_ctl_model ctl_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready));
    task automatic tick();
        @(posedge pclk);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ctl_u.xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        ctl_u.xfer(1'b0, a, 32'h0, r);
    endtask : rd
    function automatic logic pick(input int s);
        return (s == 0) ? ratio_clk_out : (s == 1) ? leaf_clk_out : xcvr_clk_out[s-2];
    endfunction : pick
    task automatic wait_lvl(input int s, input logic v, output int k);
        k = 0;
        while (pick(s) !== v && k < 40) begin
            tick();
            k++;
        end
        if (k >= 40) begin
            fail_count++;
        end
    endtask : wait_lvl
    task automatic phases(input int s, output int h, output int l);
        int k;
        wait_lvl(s, 1'b0, k);
        wait_lvl(s, 1'b1, k);
        wait_lvl(s, 1'b0, h);
        wait_lvl(s, 1'b1, l);
    endtask : phases
    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], q);
            chk(q, rv[i]);
            chk(32'(pslverr), 32'(i == 5));
        end
        tick();
        chk(ratio_clk_out, 1'b1);
        chk(plain_clk_out, 1'b1);
        for (int c = 1; c < 9; c++) begin
            code = (c == 8) ? ($random(seed) & 6) + 1 : c;
            wr(A_CTRL, 32'h3);
            wr(A_RATIO, 32'(code));
            rd(A_RATIO, q);
            chk(q, 32'(code));
            wr(A_CTRL, 32'h1);
            tick();
            chk(ratio_clk_out, 1'b1);
            repeat (20) tick();
            ex = {(code + 1) / 2, code + 1 - (code + 1) / 2};
            phases(0, hi, lo);
            chk(32'(hi), 32'(ex[0]));
            chk(32'(lo), 32'(ex[1]));
        end
        wr(A_CTRL, 32'h3);
        wr(A_RATIO, 32'h7);
        wr(A_CTRL, 32'h1);
        wait_lvl(0, 1'b1, n);
        wr(A_CTRL, 32'h0);
        repeat (10) begin
            tick();
            chk(ratio_clk_out, 1'b1);
        end
        wr(A_CTRL, 32'h2);
        #1;
        chk(ratio_clk_out, 1'b0);
        // Three-stage enable mode leaving clear with enable set
        wr(A_CTRL, 32'h9);
        wait_lvl(0, 1'b1, n);
        chk(32'(n), 32'h4);
        for (int c = 1; c < 4; c++) begin
            // Leaf held clear while its ratio changes
            wr(A_LEAF, 32'(4 + c));
            wr(A_LEAF, 32'(c));
            phases(1, hi, lo);
            chk(32'(hi + lo), 32'(1 << c));
        end
        rd(A_STATUS, q);
        chk(q, 32'h7);
        wr(A_SCLR_LO, 32'h1);
        wr(A_BUF_BASE, 32'h3);
        wr(A_BUF_BASE + 8'h4, 32'h7);
        wr(A_BUF_BASE + 8'h4, 32'h17);
        tick();
        chk(xcvr_clk_out[0], 1'b0);
        phases(3, hi, lo);
        chk(32'(hi), 32'h4);
        wr(A_SCLR_LO, 32'h0);
        wait_lvl(2, 1'b1, n);
        chk(32'(n), 32'(XCVR_REL_STAGES + 1));
        phases(2, hi, lo);
        chk(32'(hi), 32'h2);
        // Shared enable dropped: buffer level freezes after the sync flops
        wr(A_SEN_LO, 32'h0);
        repeat (3) tick();
        hi = int'(xcvr_clk_out[0]);
        repeat (10) tick();
        chk(32'(xcvr_clk_out[0]), 32'(hi));
        final_report();
    end
    initial begin
        #100000;
        fail_count++;
        final_report();
    end
endmodule : gcd_clock_divider_tb
bind gcd_clock_divider gcd_clock_divider_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .ratio_clk_out(ratio_clk_out), .plain_clk_out(plain_clk_out));
